// ==== design/pbc_basic_control.sv ====
// basic mode control register, bits 10 down to 0, with isolate and collision test
// assumes a simple register port (write strobe, read data registered) from the management block
// Summary of operation
// R1 - While isolate is one the transmit inputs are ignored and mii outputs are released.
// R2 - Isolate resets to one when the sampled phy address is zero, else to zero.
// R3 - Writing one to restart starts negotiation, reads one until it starts, then self-clears.
// R4 - With negotiation disabled the restart bit has no effect.
// R5 - Clearing restart by software does not disturb a running negotiation.
// R6 - Duplex bit picks full when one and half when zero, only with negotiation off.
// R7 - Duplex loads from the two negotiation straps at reset and stays writable.
// R8 - With collision test on, collision rises within 512 bit times of transmit enable.
// R9 - With collision test on, collision falls within 4 bit times of enable falling.
// R10 - Bits 6 to 0 ignore writes and read as zero.
// R11 - With negotiation enabled, manual duplex and speed are ignored.
// R12 - Strap defaults are captured once as reset releases and then held.
`timescale 1ns/1ps
module pbc_basic_control
   import pbc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [4:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic ANEG_ENABLE,
   input wire logic [4:0] PHY_ADDR,
   input wire logic NEGOTIATION_STRAP_A,
   input wire logic NEGOTIATION_STRAP_B,
   input wire logic ANEG_STARTED,
   input wire logic ANEG_DUPLEX,
   input wire logic TX_EN,
   input wire logic COL_CORE,
   input wire logic CRS_CORE,
   output logic [15:0] REG_RDATA,
   output logic ANEG_RESTART,
   output logic FULL_DUPLEX,
   output logic TX_EN_CORE,
   output logic COL,
   output logic CRS,
   output logic MII_OE,
   output logic ISOLATE
);
   logic isolate_r;
   logic restart_r;
   logic duplex_r;
   logic coltest_r;
   logic strap_done_r;
   logic wr_hit;
   logic rd_hit;
   logic restart_req;
   logic [15:0] rd_word;
   logic tx_en_g;
   pbc_an_t an_r;
   pbc_an_t an_nxt;
   pbc_mii_if mif();

   // only offset zero is decoded; every other offset reads back zero
   assign wr_hit = REG_WR && (REG_ADDR == BASIC_MODE_CONTROL_OFS);
   assign rd_hit = REG_RD && (REG_ADDR == BASIC_MODE_CONTROL_OFS);
   // R4 a restart request only counts while negotiation is enabled
   assign restart_req = wr_hit && REG_WDATA[RESTART_BIT] && ANEG_ENABLE;
   assign mif.isolate = isolate_r;
   assign mif.col_test = coltest_r;

   pbc_mii_gate u_gate (
      .clk(CLK),
      .rst(RST),
      .tx_en_pin(TX_EN),
      .col_core(COL_CORE),
      .crs_core(CRS_CORE),
      .col_gated(COL),
      .crs_gated(CRS),
      .mii_oe(MII_OE),
      .tx_en_gated(tx_en_g),
      .mif(mif)
   );

   // R12 one-shot strap capture flag
   // capture waits one cycle past reset so the strap pins are read after release
   always_ff @(posedge CLK) begin
      if (RST) begin
         strap_done_r <= 1'b0;
      end else begin
         strap_done_r <= 1'b1;
      end
   end

   // R2 isolate default from address
   always_ff @(posedge CLK) begin
      if (RST) begin
         isolate_r <= ISOLATE_RST;
      end else if (!strap_done_r) begin
         isolate_r <= (PHY_ADDR == ISOLATE_ADDR);
      end else if (wr_hit) begin
         isolate_r <= REG_WDATA[ISOLATE_BIT];
      end
   end

   // R7 duplex from straps, then writable
   always_ff @(posedge CLK) begin
      if (RST) begin
         duplex_r <= DUPLEX_RST;
      end else if (!strap_done_r) begin
         duplex_r <= NEGOTIATION_STRAP_A | NEGOTIATION_STRAP_B;
      end else if (wr_hit) begin
         duplex_r <= REG_WDATA[DUPLEX_BIT];
      end
   end

   // R8 collision test enable, used by the gate
   always_ff @(posedge CLK) begin
      if (RST) begin
         coltest_r <= COLTEST_RST;
      end else if (wr_hit) begin
         coltest_r <= REG_WDATA[COLTEST_BIT];
      end
   end

   // negotiation request sequencer; restart bit mirrors the pending state
   always_comb begin
      an_nxt = an_r;
      case (an_r)
         AN_IDLE: begin
            // R4 ignored when negotiation off
            if (restart_req) begin
               an_nxt = AN_PEND;
            end
         end
         AN_PEND: begin
            // R4 a pending request is dropped when negotiation is switched off
            if (!ANEG_ENABLE) begin
               an_nxt = AN_IDLE;
            end else if (ANEG_STARTED) begin
               an_nxt = AN_RUN;
            end
         end
         AN_RUN: begin
            // R5 software clear cannot abort; a new request in this cycle must not be lost
            if (restart_req) begin
               an_nxt = AN_PEND;
            end else begin
               an_nxt = AN_IDLE;
            end
         end
         default: begin
            an_nxt = AN_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         an_r <= AN_IDLE;
      end else begin
         an_r <= an_nxt;
      end
   end

   // R3 reads one until negotiation starts
   always_ff @(posedge CLK) begin
      if (RST) begin
         restart_r <= RESTART_RST;
      end else begin
         restart_r <= (an_nxt == AN_PEND);
      end
   end

   // R3 request to the negotiation engine, kept in step with the register bit
   always_ff @(posedge CLK) begin
      if (RST) begin
         ANEG_RESTART <= RESTART_RST;
      end else begin
         ANEG_RESTART <= (an_nxt == AN_PEND);
      end
   end

   // R6 R11 duplex resolution
   // registered so the mode pin never glitches while the enable changes
   always_ff @(posedge CLK) begin
      if (RST) begin
         FULL_DUPLEX <= 1'b0;
      end else begin
         FULL_DUPLEX <= ANEG_ENABLE ? ANEG_DUPLEX : duplex_r;
      end
   end

   // R10 read word; upper and reserved bits are tied so software always sees zero there
   always_comb begin
      rd_word = 16'h0000;
      rd_word[ISOLATE_BIT] = isolate_r;
      rd_word[RESTART_BIT] = restart_r;
      rd_word[DUPLEX_BIT] = duplex_r;
      rd_word[COLTEST_BIT] = coltest_r;
      rd_word[6:0] = RESERVED_READ;
   end

   // R10 reserved bits read zero
   always_ff @(posedge CLK) begin
      if (RST) begin
         REG_RDATA <= 16'h0000;
      end else if (rd_hit) begin
         REG_RDATA <= rd_word;
      end else begin
         REG_RDATA <= 16'h0000;
      end
   end

   // R1 gated transmit enable toward the core
   always_ff @(posedge CLK) begin
      if (RST) begin
         TX_EN_CORE <= 1'b0;
      end else begin
         TX_EN_CORE <= tx_en_g;
      end
   end

   // R1 isolate copy for the pins outside; starts high so nothing drives during reset
   always_ff @(posedge CLK) begin
      if (RST) begin
         ISOLATE <= ISOLATE_RST;
      end else begin
         ISOLATE <= isolate_r;
      end
   end
endmodule : pbc_basic_control

// ==== design/pbc_mii_gate.sv ====
// isolate gating and collision test generator on the mii
// assumes tx inputs are synchronous to CLK and output enables resolve the pins outside
`timescale 1ns/1ps
module pbc_mii_gate
   import pbc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tx_en_pin,
   input wire logic col_core,
   input wire logic crs_core,
   output logic col_gated,
   output logic crs_gated,
   output logic mii_oe,
   output logic tx_en_gated,
   pbc_mii_if.gate mif
);
   logic [3:0] on_cnt_r;
   logic col_test_r;
   // R1 ignore transmit inputs
   assign tx_en_gated = tx_en_pin & ~mif.isolate;
   // R8 collision follows enable
   always_ff @(posedge clk) begin
      if (rst || !mif.col_test || !tx_en_gated) begin
         on_cnt_r <= 4'h0;
      end else if (on_cnt_r < 4'(COL_TEST_DLY)) begin
         on_cnt_r <= on_cnt_r + 4'h1;
      end
   end
   // R9 drop collision one cycle after enable falls, well within 4 bit times
   always_ff @(posedge clk) begin
      if (rst) begin
         col_test_r <= 1'b0;
      end else begin
         col_test_r <= mif.col_test && tx_en_gated && (on_cnt_r >= 4'(COL_TEST_DLY - 1));
      end
   end
   // R1 outputs released while isolated
   always_ff @(posedge clk) begin
      if (rst) begin
         col_gated <= 1'b0;
         crs_gated <= 1'b0;
         mii_oe <= 1'b0;
      end else begin
         col_gated <= (col_core | (col_test_r & tx_en_gated)) & ~mif.isolate;
         crs_gated <= crs_core & ~mif.isolate;
         mii_oe <= ~mif.isolate;
      end
   end
endmodule : pbc_mii_gate

// ==== design/pbc_mii_if.sv ====
// interface carrying the isolate and collision test mode signals from the control to the isolate gate
// assumes the control module drives both mode signals and the gate only reads them
`timescale 1ns/1ps
interface pbc_mii_if;
   logic isolate;
   logic col_test;
   modport ctrl (output isolate, output col_test);
   modport gate (input isolate, input col_test);
endinterface : pbc_mii_if

// ==== design/pbc_pkg.sv ====
// package for the basic mode control low-bits block
// assumes a single 100 MHz clock domain and a register port with write strobe and 16-bit data
package pbc_pkg;
   localparam logic [4:0] BASIC_MODE_CONTROL_OFS = 5'h00;
   localparam int ISOLATE_BIT = 10;
   localparam int RESTART_BIT = 9;
   localparam int DUPLEX_BIT = 8;
   localparam int COLTEST_BIT = 7;
   localparam int ANEG_EN_BIT = 12;
   localparam logic [4:0] ISOLATE_ADDR = 5'h00;
   localparam logic RESTART_RST = 1'b0;
   localparam logic COLTEST_RST = 1'b0;
   localparam logic ISOLATE_RST = 1'b1;
   localparam logic DUPLEX_RST = 1'b0;
   localparam logic [6:0] RESERVED_READ = 7'h00;
   // clock period in ns and bit time at 10 Mb/s (slowest rate) in ns
   localparam int CLK_NS = 10;
   localparam int BIT_TIME_NS = 100;
   // collision test limits in bit times
   localparam int COL_ON_BT = 512;
   localparam int COL_OFF_BT = 4;
   // on-delay is a longest time: round down
   localparam int COL_ON_CYC = (COL_ON_BT * BIT_TIME_NS) / CLK_NS;
   localparam int COL_OFF_CYC = (COL_OFF_BT * BIT_TIME_NS) / CLK_NS;
   // delay actually used before raising collision in test mode
   localparam int COL_TEST_DLY = 4;
   typedef enum logic [2:0] {
      AN_IDLE = 3'h1,
      AN_PEND = 3'h2,
      AN_RUN = 3'h4
   } pbc_an_t;
endpackage : pbc_pkg

// ==== test/pbc_basic_control_assertions.sv ====
// port-level checker for the basic mode control low bits
// assumes it is bound to pbc_basic_control and sees only its ports
`timescale 1ns/1ps
module pbc_bc_chk(
   input wire logic CLK,
   input wire logic RST,
   input wire logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   input wire logic ANEG_ENABLE,
   input wire logic ANEG_STARTED,
   input wire logic ANEG_DUPLEX,
   input wire logic ANEG_RESTART,
   input wire logic FULL_DUPLEX,
   input wire logic TX_EN,
   input wire logic COL_CORE,
   input wire logic TX_EN_CORE,
   input wire logic COL,
   input wire logic MII_OE,
   input wire logic ISOLATE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // both copies must agree, so the cycle where isolate changes is skipped
   sequence iso_s;
      ISOLATE && $past(ISOLATE);
   endsequence
   sequence tx_drop_s;
      $fell(TX_EN) && !COL_CORE;
   endsequence
   iso_out_a: assert property (iso_s |-> !COL && !MII_OE) else $error("mii driven");
   iso_tx_a: assert property (iso_s |-> !TX_EN_CORE) else $error("tx passed");
   col_off_a: assert property (tx_drop_s |-> ##[1:4] !COL) else $error("col held");
   rd_resv_a: assert property (REG_RDATA[6:0] == 7'h00) else $error("reserved set");
   rd_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000) else $error("rdata");
   rst_clear_a: assert property (ANEG_RESTART && ANEG_STARTED |=> !ANEG_RESTART)
      else $error("restart stuck");
   rst_noan_a: assert property (!ANEG_ENABLE |=> !ANEG_RESTART) else $error("restart");
   dup_an_a: assert property ($past(ANEG_ENABLE) |-> FULL_DUPLEX == $past(ANEG_DUPLEX))
      else $error("duplex");
endmodule : pbc_bc_chk
bind pbc_basic_control pbc_bc_chk u_chk (.CLK(CLK), .RST(RST), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .ANEG_ENABLE(ANEG_ENABLE), .ANEG_STARTED(ANEG_STARTED),
   .ANEG_DUPLEX(ANEG_DUPLEX), .ANEG_RESTART(ANEG_RESTART), .FULL_DUPLEX(FULL_DUPLEX),
   .TX_EN(TX_EN), .COL_CORE(COL_CORE), .TX_EN_CORE(TX_EN_CORE), .COL(COL),
   .MII_OE(MII_OE), .ISOLATE(ISOLATE));

// ==== test/pbc_basic_control_tb.sv ====
// self-checking bench for the basic mode control low bits
// assumes the mac model and the bound checker
`timescale 1ns/1ps
module pbc_basic_control_tb;
   import pbc_pkg::*;
   logic clk = 0, rst = 1, wr = 0, rd = 0, an_en = 0, st_a = 0, an_go = 0, an_dup = 0;
   logic crs_c = 0, col_c = 0, st_b = 0, go = 0, rd_q = 0;
   logic restart, fdx, txc, col, crs, oe, iso, tx_en;
   logic [4:0] phy = 5'h00, addr = 5'h00;
   logic [15:0] wdata = 16'h0000, rdata, d;
   logic [15:0] exp_q[$];
   integer seed = 32'h27be4e0a, miscompares = 0, check_count = 0, i;
   pbc_basic_control u_pbc_basic_control (.CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd),
      .REG_ADDR(addr), .REG_WDATA(wdata), .ANEG_ENABLE(an_en), .PHY_ADDR(phy),
      .NEGOTIATION_STRAP_A(st_a), .NEGOTIATION_STRAP_B(st_b), .ANEG_STARTED(an_go),
      .ANEG_DUPLEX(an_dup), .TX_EN(tx_en), .COL_CORE(col_c), .CRS_CORE(crs_c),
      .REG_RDATA(rdata), .ANEG_RESTART(restart), .FULL_DUPLEX(fdx), .TX_EN_CORE(txc),
      .COL(col), .CRS(crs), .MII_OE(oe), .ISOLATE(iso));
   pbc_mac_model u_pbc_mac_model (.clk(clk), .go(go), .len(8'h14), .tx_en(tx_en));
   always #5 clk = ~clk;
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic chk_rd(input logic [15:0] e, input logic [15:0] s);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH rdata exp %h got %h", e, s);
      end
   endtask : chk_rd
   task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] v, e);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= v;
      if (!w) exp_q.push_back(e);
      @(posedge clk);
      wr <= 0;
      rd <= 0;
   endtask : acc
   task automatic rst_seq(input logic [4:0] p, input logic a, input logic b);
      rst <= 1;
      phy <= p;
      st_a <= a;
      st_b <= b;
      repeat (12) @(posedge clk);
      rst <= 0;
      repeat (3) @(posedge clk);
   endtask : rst_seq
   task automatic frame;
      go <= 1;
      @(posedge clk);
      go <= 0;
   endtask : frame
   task automatic end_sim;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   always @(posedge clk) rd_q <= rd;
   always @(negedge clk) if (rd_q) chk_rd(exp_q.pop_front(), rdata);
   initial begin
      #60000;
      miscompares++;
      end_sim;
   end
   initial begin
      rst_seq(5'h00, 0, 0);
      acc(0, 5'h00, 0, 16'h0400);
      rst_seq(5'h01 | 5'($random(seed)), 1, 0);
      acc(0, 5'h00, 0, 16'h0100);
      rst_seq(5'h10 | 5'($random(seed)), 0, 1);
      acc(0, 5'h00, 0, 16'h0100);
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         crs_c <= d[0];
         col_c <= d[1];
         acc(1, 5'h00, d, 0);
         acc(0, 5'h00, 0, d & 16'h0580);
         acc(0, 5'h03, 0, 0);
         @(negedge clk);
         chk("duplex", 16'(d[8]), 16'(fdx));
         chk("crs", 16'(d[0] & ~d[10]), 16'(crs));
         chk("col", 16'(d[1] & ~d[10]), 16'(col));
         chk("restart", 16'h0000, 16'(restart));
         @(posedge clk);
      end
      an_en <= 1;
      an_dup <= 1;
      col_c <= 0;
      acc(1, 5'h00, 16'h0200, 0);
      @(negedge clk);
      chk("restart", 16'h0001, 16'(restart));
      acc(1, 5'h00, 16'h0000, 0);
      acc(0, 5'h00, 0, 16'h0200);
      an_go <= 1;
      @(posedge clk);
      an_go <= 0;
      acc(0, 5'h00, 0, 16'h0000);
      @(negedge clk);
      chk("an_duplex", 16'h0001, 16'(fdx));
      chk("restart", 16'h0000, 16'(restart));
      @(posedge clk);
      an_en <= 0;
      acc(1, 5'h00, 16'h0080, 0);
      frame;
      for (i = 0; i < 6000 && col !== 1'b1; i++) @(negedge clk);
      chk("col_on", 16'h0001, 16'(i <= COL_ON_CYC));
      repeat (40) @(negedge clk);
      chk("col_off", 16'h0000, 16'(col));
      acc(1, 5'h00, 16'h0480, 0);
      frame;
      repeat (10) @(negedge clk);
      chk("isolate", 16'h0008, 16'({iso, col, oe, txc}));
      repeat (30) @(posedge clk);
      end_sim;
   end
endmodule : pbc_basic_control_tb

// ==== test/pbc_mac_model.sv ====
// mac side model: holds transmit enable for a frame of len cycles
// assumes go is a one-cycle request synchronous to clk
`timescale 1ns/1ps
module pbc_mac_model(
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] len,
   output logic tx_en
);
   logic [7:0] cnt_r = 8'h00;
   always @(posedge clk) begin
      if (go)
         cnt_r <= len;
      else if (cnt_r != 8'h00)
         cnt_r <= cnt_r - 8'h01;
   end
   assign tx_en = cnt_r != 8'h00;
endmodule : pbc_mac_model
